// *** hw/pwr_mode_pkg.sv ***
package pwr_mode_pkg;

   // Register offsets on the documented register port.
   localparam logic [7:0] ADDR_PORT1_PHY_CONTROL  = 8'h1d;
   localparam logic [7:0] ADDR_PORT2_PHY_CONTROL  = 8'h2d;
   localparam logic [7:0] ADDR_POWER_MODE_CONTROL = 8'hc3;
   localparam logic [7:0] ADDR_SLEEP_DELAY_TIME   = 8'hc4;

   // Field positions.
   localparam int MODE_LSB          = 0;
   localparam int PLL_OFF_BIT       = 2;
   localparam int PORT_CHIP_SLEEP_PIN_N_BIT    = 3;

   // Reset values.
   localparam logic [7:0] RST_POWER_MODE = 8'h00;
   localparam logic [7:0] RST_SLEEP_TIME = 8'h00;
   localparam logic [7:0] RST_PORT_CTRL  = 8'h00;

   // Timing: clock 10 MHz.
   localparam int CLK_HZ            = 10_000_000;
   localparam int CLK_NS            = 100;
   localparam int PULSE_NS          = 120;
   // Least width rounds up to whole cycles.
   localparam int PULSE_CYC         = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_PERIOD_S    = 1;
   localparam int PULSE_PERIOD_CYC  = CLK_HZ * PULSE_PERIOD_S;
   // Go-sleep time unit: one step of the sleep field is one millisecond.
   localparam int SLEEP_UNIT_MS     = 1;
   localparam int SLEEP_UNIT_CYC    = CLK_HZ / 1000 * SLEEP_UNIT_MS;

   typedef enum logic [1:0] {
      MODE_NORMAL    = 2'b00,
      MODE_ENERGY    = 2'b01,
      MODE_SOFT_DOWN = 2'b10,
      MODE_SAVING    = 2'b11
   } mode_t;

   // Register access request.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Power gating outputs of the block.
   typedef struct packed {
      logic       pll_en;
      logic       mac_en;
      logic       host_en;
      logic [1:0] phy_tx_en;
      logic [1:0] phy_rx_en;
      logic       energy_det_en;
      logic       chip_off;
   } gate_t;

endpackage

// *** hw/pin_sync.sv ***
`timescale 1ns/100ps
// Three-stage synchroniser; the output moves once stages two and three agree.
module pin_sync
   import pwr_mode_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
)(
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst,
   // Pin and clean level.
   input  wire logic pin,
   output logic      level
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } sync_st_t;

   sync_st_t st;
   sync_st_t next_st;

   // The first stage feeds only the second stage.
   always_comb begin
      next_st     = st;
      next_st.s1  = pin;
      next_st.s2  = st.s1;
      next_st.s3  = st.s2;
      if (st.s2 == st.s3) begin
         next_st.lvl = st.s3;
      end
   end

   // Register the state.
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end else begin
         st <= next_st;
      end
   end

   assign level = st.lvl;

endmodule // pin_sync

// *** hw/switch_power_mode_control.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - Mode field decodes normal, energy, soft-down, saving.
// - Mode field resets to normal operation.
// - Normal mode runs clocks, PHY, MAC, host.
// - From normal, host may select any mode.
// - Energy mode sleeps after idle exceeds go-sleep.
// - Low power state disables all but detector.
// - Energy in low power returns to normal.
// - Energy mode emits 200 ns pulse each second.
// - Bit 2 with energy mode disables PLL.
// - Soft power-down stops clocks, PHY, MAC.
// - Writing 00 leaves soft power-down.
// - Saving mode needs autoneg on, cable out.
// - Saving mode keeps transmitter, gates idle receiver.
// - Saving mode wakes PHY on cable activity.
// - From saving, host may select any mode.
// - Port bit 3 powers down that port alone.
// - Low power-down pin turns the chip off.
module switch_power_mode_control
   import pwr_mode_pkg::*;
(
   // Clock and reset.
   input  wire logic       CLK,
   input  wire logic       SYS_RST,
   // Register port.
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   output logic [7:0]      REG_RDATA,
   output logic            REG_ACK,
   // Line status per port, from the PHY analog side.
   input  wire logic [1:0] CABLE_ENERGY,
   input  wire logic       AUTONEG_EN,
   // Power-down pin, active low.
   input  wire logic       CHIP_SLEEP_PIN_N,
   // Gating outputs.
   output logic            PLL_EN,
   output logic            MAC_EN,
   output logic            HOST_EN,
   output logic [1:0]      PHY_TX_EN,
   output logic [1:0]      PHY_RX_EN,
   output logic            ENERGY_DET_EN,
   output logic            CHIP_OFF,
   output logic            LOW_POWER,
   output logic [1:0]      LINK_PULSE
);

   typedef struct packed {
      logic [7:0]  power_mode;
      logic [7:0]  sleep_time;
      logic [7:0]  port1_ctrl;
      logic [7:0]  port2_ctrl;
      logic        low_power;
      logic [7:0]  idle_units;
      logic [23:0] unit_cnt;
      logic [23:0] sec_cnt;
      logic [1:0]  pulse_cnt;
      logic [7:0]  rdata;
      logic        ack;
      gate_t       gate;
   } ctl_st_t;

   ctl_st_t    st;
   ctl_st_t    next_st;
   logic [1:0] energy;
   logic       pin_n;
   reg_req_t   req;
   mode_t      mode;
   logic       any_energy;
   logic [1:0] port_down;

   // Pins from the line side are asynchronous to CLK.
   for (genvar i = 0; i < 2; i++) begin : g_energy_sync
      pin_sync #(.RST_VAL(1'b0)) u_sync (
         .clk   (CLK),
         .rst   (SYS_RST),
         .pin   (CABLE_ENERGY[i]),
         .level (energy[i])
      );
   end

   pin_sync #(.RST_VAL(1'b1)) u_pin_sync (
      .clk   (CLK),
      .rst   (SYS_RST),
      .pin   (CHIP_SLEEP_PIN_N),
      .level (pin_n)
   );

   // Bundle the register request and decode the mode field.
   always_comb begin
      req.wr     = REG_WR;
      req.rd     = REG_RD;
      req.addr   = REG_ADDR;
      req.wdata  = REG_WDATA;
      mode       = mode_t'(st.power_mode[MODE_LSB +: 2]);
      any_energy = |energy;
      port_down  = {st.port2_ctrl[PORT_CHIP_SLEEP_PIN_N_BIT], st.port1_ctrl[PORT_CHIP_SLEEP_PIN_N_BIT]};
   end

   // Next-state logic for registers, sleep timer, pulse generator and gating.
   always_comb begin
      next_st     = st;
      next_st.ack = 1'b0;

      // Register access. The mode register stays writable in every mode so
      // software can always leave soft power-down; other registers follow
      // the host interface gate.
      if (req.wr) begin
         if (req.addr == ADDR_POWER_MODE_CONTROL) begin
            next_st.power_mode = req.wdata;
            next_st.low_power  = 1'b0;
            next_st.idle_units = 8'h00;
            next_st.unit_cnt   = 24'h000000;
         end else if (st.gate.host_en) begin
            case (req.addr)
               ADDR_SLEEP_DELAY_TIME:  next_st.sleep_time = req.wdata;
               ADDR_PORT1_PHY_CONTROL: next_st.port1_ctrl = req.wdata;
               ADDR_PORT2_PHY_CONTROL: next_st.port2_ctrl = req.wdata;
               default:                next_st.sleep_time = st.sleep_time;
            endcase
         end
         next_st.ack = 1'b1;
      end else if (req.rd) begin
         case (req.addr)
            ADDR_POWER_MODE_CONTROL: next_st.rdata = st.power_mode;
            ADDR_SLEEP_DELAY_TIME:   next_st.rdata = st.sleep_time;
            ADDR_PORT1_PHY_CONTROL:  next_st.rdata = st.port1_ctrl;
            ADDR_PORT2_PHY_CONTROL:  next_st.rdata = st.port2_ctrl;
            default:                 next_st.rdata = 8'h00;
         endcase
         next_st.ack = 1'b1;
      end

      // Idle timer for energy-detect mode, counted in go-sleep units. Only a mode write
      // or cable energy restarts it; cable energy must wake the device whatever else the host writes.
      if (mode == MODE_ENERGY && !(req.wr && req.addr == ADDR_POWER_MODE_CONTROL)) begin
         if (any_energy) begin
            next_st.low_power  = 1'b0;
            next_st.idle_units = 8'h00;
            next_st.unit_cnt   = 24'h000000;
         end else if (!st.low_power) begin
            if (st.unit_cnt == 24'(SLEEP_UNIT_CYC - 1)) begin
               next_st.unit_cnt = 24'h000000;
               if (st.idle_units >= st.sleep_time) begin
                  next_st.low_power = 1'b1;
               end else begin
                  next_st.idle_units = st.idle_units + 8'h01;
               end
            end else begin
               next_st.unit_cnt = st.unit_cnt + 24'h000001;
            end
         end
      end

      if (mode == MODE_ENERGY) begin
         if (st.sec_cnt == 24'(PULSE_PERIOD_CYC - 1)) begin
            next_st.sec_cnt   = 24'h000000;
            next_st.pulse_cnt = 2'(PULSE_CYC);
         end else begin
            next_st.sec_cnt = st.sec_cnt + 24'h000001;
            if (st.pulse_cnt != 2'h0) begin
               next_st.pulse_cnt = st.pulse_cnt - 2'h1;
            end
         end
      end else begin
         // Outside energy mode the timer waits at its last count, so the first pulse
         // leaves one cycle after the mode is entered and a partner hears the port at once.
         next_st.sec_cnt   = 24'(PULSE_PERIOD_CYC - 1);
         next_st.pulse_cnt = 2'h0;
      end

      // Gating per mode.
      next_st.gate.chip_off      = 1'b0;
      next_st.gate.energy_det_en = 1'b0;
      case (mode)
         MODE_NORMAL: begin
            next_st.gate.pll_en    = 1'b1;
            next_st.gate.mac_en    = 1'b1;
            next_st.gate.host_en   = 1'b1;
            next_st.gate.phy_tx_en = 2'b11;
            next_st.gate.phy_rx_en = 2'b11;
         end
         MODE_ENERGY: begin
            next_st.gate.energy_det_en = 1'b1;
            next_st.gate.pll_en  = !st.low_power && !st.power_mode[PLL_OFF_BIT];
            next_st.gate.mac_en    = !st.low_power;
            next_st.gate.host_en   = !st.low_power;
            next_st.gate.phy_tx_en = st.low_power ? 2'b00 : 2'b11;
            next_st.gate.phy_rx_en = st.low_power ? 2'b00 : 2'b11;
         end
         MODE_SOFT_DOWN: begin
            next_st.gate.pll_en    = 1'b0;
            next_st.gate.mac_en    = 1'b0;
            next_st.gate.host_en   = 1'b0;
            next_st.gate.phy_tx_en = 2'b00;
            next_st.gate.phy_rx_en = 2'b00;
         end
         MODE_SAVING: begin
            next_st.gate.pll_en    = 1'b1;
            next_st.gate.mac_en    = 1'b1;
            next_st.gate.host_en   = 1'b1;
            next_st.gate.phy_tx_en = 2'b11;
            next_st.gate.phy_rx_en = AUTONEG_EN ? energy : 2'b11;
         end
         default: begin
            next_st.gate = st.gate;
         end
      endcase

      next_st.gate.phy_tx_en = next_st.gate.phy_tx_en & ~port_down;
      next_st.gate.phy_rx_en = next_st.gate.phy_rx_en & ~port_down;

      if (!pin_n) begin
         next_st.gate = '{pll_en: 1'b0, mac_en: 1'b0, host_en: 1'b0,
                          phy_tx_en: 2'b00, phy_rx_en: 2'b00,
                          energy_det_en: 1'b0, chip_off: 1'b1};
      end
   end

   // Register all state; the reset value selects normal mode.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st            <= '0;
         st.power_mode <= RST_POWER_MODE;
         st.sleep_time <= RST_SLEEP_TIME;
         st.port1_ctrl <= RST_PORT_CTRL;
         st.port2_ctrl <= RST_PORT_CTRL;
         st.gate       <= '{pll_en: 1'b1, mac_en: 1'b1, host_en: 1'b1,
                            phy_tx_en: 2'b11, phy_rx_en: 2'b11,
                            energy_det_en: 1'b0, chip_off: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Outputs come from flip-flops, except LINK_PULSE, which is gated from registered state.
   assign REG_RDATA     = st.rdata;
   assign REG_ACK       = st.ack;
   assign PLL_EN        = st.gate.pll_en;
   assign MAC_EN        = st.gate.mac_en;
   assign HOST_EN       = st.gate.host_en;
   assign PHY_TX_EN     = st.gate.phy_tx_en;
   assign PHY_RX_EN     = st.gate.phy_rx_en;
   assign ENERGY_DET_EN = st.gate.energy_det_en;
   assign CHIP_OFF      = st.gate.chip_off;
   assign LOW_POWER     = st.low_power;
   assign LINK_PULSE    = (st.pulse_cnt != 2'h0 && !st.gate.chip_off) ? ~port_down : 2'b00;

   // Assertions.
   // reset gives normal mode
   a_reset_mode_normal: assert property (@(posedge CLK)
      !SYS_RST && $past(SYS_RST) |-> st.power_mode[1:0] == 2'b00)
      else $error("mode not 00 after reset");
   a_reset_gates_on: assert property (@(posedge CLK)
      !SYS_RST && $past(SYS_RST) |-> PLL_EN && MAC_EN && HOST_EN && PHY_TX_EN == 2'b11)
      else $error("blocks gated after reset");
   a_energy_decode: assert property (@(posedge CLK) disable iff (SYS_RST)
      pin_n |=> ENERGY_DET_EN == ($past(mode) == MODE_ENERGY))
      else $error("energy detector enable wrong");
   a_soft_down_off: assert property (@(posedge CLK) disable iff (SYS_RST)
      mode == MODE_SOFT_DOWN && $stable(mode) |=> !PLL_EN && !MAC_EN && PHY_TX_EN == 2'b00)
      else $error("soft power-down left blocks on");
   sequence s_wake_write;
      mode == MODE_SOFT_DOWN && REG_WR && REG_ADDR == ADDR_POWER_MODE_CONTROL
         && REG_WDATA == 8'h00;
   endsequence
   a_soft_wake: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_wake_write ##1 pin_n |=> PLL_EN && MAC_EN && HOST_EN)
      else $error("soft power-down did not wake");
   a_mode_write_lands: assert property (@(posedge CLK) disable iff (SYS_RST)
      REG_WR && REG_ADDR == ADDR_POWER_MODE_CONTROL |=> st.power_mode == $past(REG_WDATA))
      else $error("mode write lost");
   a_low_power_gates: assert property (@(posedge CLK) disable iff (SYS_RST)
      st.low_power && mode == MODE_ENERGY && pin_n ##1 st.low_power |->
      !PLL_EN && !HOST_EN && ENERGY_DET_EN) else $error("low power gating wrong");
   a_energy_wakes: assert property (@(posedge CLK) disable iff (SYS_RST)
      mode == MODE_ENERGY && any_energy |=> !LOW_POWER) else $error("no wake on energy");
   a_pll_off: assert property (@(posedge CLK) disable iff (SYS_RST)
      mode == MODE_ENERGY && st.power_mode[PLL_OFF_BIT] |=> !PLL_EN)
      else $error("PLL still on with disable bit");
   // each link pulse spans two cycles
   sequence s_pulse_rise;
      st.pulse_cnt == 2'h0 ##1 (st.pulse_cnt != 2'h0 && mode == MODE_ENERGY);
   endsequence
   sequence s_pulse_fall;
      st.pulse_cnt != 2'h0 ##1 st.pulse_cnt == 2'h0;
   endsequence
   a_pulse_width: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_pulse_rise ##1 mode == MODE_ENERGY |-> s_pulse_fall)
      else $error("link pulse width wrong");
   a_port_down: assert property (@(posedge CLK) disable iff (SYS_RST)
      port_down[0] && $stable(port_down) |=> !PHY_TX_EN[0] && !PHY_RX_EN[0])
      else $error("port 1 not powered down");
   a_port2_down: assert property (@(posedge CLK) disable iff (SYS_RST)
      port_down[1] |=> !PHY_TX_EN[1] && !PHY_RX_EN[1])
      else $error("port 2 not powered down");
   sequence s_pin_low;
      !pin_n;
   endsequence
   a_pin_chip_off: assert property (@(posedge CLK) disable iff (SYS_RST)
      s_pin_low |=> CHIP_OFF && !PLL_EN) else $error("pin did not power down chip");
   a_normal_all_on: assert property (@(posedge CLK) disable iff (SYS_RST)
      mode == MODE_NORMAL && pin_n && port_down == 2'b00 ##1 mode == MODE_NORMAL |->
      PLL_EN && MAC_EN && HOST_EN && PHY_TX_EN == 2'b11) else $error("normal mode gated");
   a_saving_active: assert property (@(posedge CLK) disable iff (SYS_RST)
      mode == MODE_SAVING && pin_n |=> PLL_EN && MAC_EN && HOST_EN)
      else $error("saving mode gated core blocks");
   a_saving_tx_on: assert property (@(posedge CLK) disable iff (SYS_RST)
      mode == MODE_SAVING && pin_n && port_down == 2'b00 ##1 mode == MODE_SAVING |->
      PHY_TX_EN == 2'b11 && PLL_EN) else $error("saving mode dropped transmitter");
   a_saving_rx_follow: assert property (@(posedge CLK) disable iff (SYS_RST)
      mode == MODE_SAVING && AUTONEG_EN && pin_n |=>
      PHY_RX_EN == ($past(energy) & ~$past(port_down)))
      else $error("saving receivers ignore line status");

endmodule // switch_power_mode_control

// *** tb/switch_power_mode_control_bench.sv ***
`timescale 1ns/100ps
module switch_power_mode_control_bench
   import pwr_mode_pkg::*;
;
   logic       clk = 1'h0;
   logic       sys_rst = 1'h1;
   logic       reg_wr = 1'h0;
   logic       reg_rd = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic       reg_ack;
   logic [1:0] cable_energy = 2'h0;
   logic       autoneg_en = 1'h0;
   logic       chip_sleep_pin_n = 1'h1;
   logic       pll_en, mac_en, host_en, energy_det_en, chip_off, low_power;
   logic [1:0] phy_tx_en, phy_rx_en, link_pulse;
   logic [7:0] rd_byte;
   int         num_errors = 0;
   int         tests_run = 0;

   // Expected gating patterns: all on, soft power-down, pin held low.
   localparam gate_t G_ON   = {1'h1, 1'h1, 1'h1, 2'h3, 2'h3, 1'h0, 1'h0};
   localparam gate_t G_SOFT = {1'h0, 1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0};
   localparam gate_t G_PIN  = {1'h0, 1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 1'h1};

   // Clock of 100 ns period.
   always #50 clk = ~clk;

   switch_power_mode_control dut_u (
      .CLK(clk), .SYS_RST(sys_rst),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_RDATA(reg_rdata), .REG_ACK(reg_ack),
      .CABLE_ENERGY(cable_energy), .AUTONEG_EN(autoneg_en),
      .CHIP_SLEEP_PIN_N(chip_sleep_pin_n),
      .PLL_EN(pll_en), .MAC_EN(mac_en), .HOST_EN(host_en), .PHY_TX_EN(phy_tx_en),
      .PHY_RX_EN(phy_rx_en), .ENERGY_DET_EN(energy_det_en), .CHIP_OFF(chip_off),
      .LOW_POWER(low_power), .LINK_PULSE(link_pulse)
   );

   // Gating outputs gathered in the package's field order.
   function automatic gate_t seen_gate();
      seen_gate = {pll_en, mac_en, host_en, phy_tx_en, phy_rx_en, energy_det_en, chip_off};
   endfunction

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_gate(input string what, input gate_t exp);
      gate_t got;
      got = seen_gate();
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One-cycle strobe; the acknowledge is looked at in the cycle after it.
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk);
      reg_wr = 1'h1;
      reg_addr = addr;
      reg_wdata = data;
      @(negedge clk);
      reg_wr = 1'h0;
      check8("write ack", 8'h01, {7'h00, reg_ack});
      @(negedge clk);
   endtask

   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk);
      reg_rd = 1'h1;
      reg_addr = addr;
      @(negedge clk);
      reg_rd = 1'h0;
      check8("read ack", 8'h01, {7'h00, reg_ack});
      data = reg_rdata;
   endtask

   task automatic read_check(input string what, input logic [7:0] addr, input logic [7:0] exp);
      reg_read(addr, rd_byte);
      check8(what, exp, rd_byte);
   endtask

   // Waits for the low power flag under a bound; a miss counts as a mismatch.
   task automatic wait_low(input logic v, input int max);
      int n;
      n = 0;
      while (low_power !== v && n < max) begin
         @(negedge clk);
         n++;
      end
      check8("low power flag", {7'h00, v}, {7'h00, low_power});
   endtask

   // A hang is cut short well beyond the some twenty thousand cycles the tests need.
   initial begin
      repeat (80000) @(posedge clk);
      num_errors++;
      $display("CHECK FAILED watchdog expected done seen hang");
      end_sim();
   end

   initial begin
      repeat (12) @(negedge clk);
      sys_rst = 1'h0;
      repeat (4) @(negedge clk);
      read_check("mode reset", ADDR_POWER_MODE_CONTROL, RST_POWER_MODE);
      read_check("sleep reset", ADDR_SLEEP_DELAY_TIME, RST_SLEEP_TIME);
      read_check("port1 reset", ADDR_PORT1_PHY_CONTROL, RST_PORT_CTRL);
      read_check("port2 reset", ADDR_PORT2_PHY_CONTROL, RST_PORT_CTRL);
      read_check("unmapped read", 8'h55, 8'h00);
      check_gate("normal gating", G_ON);
      $display("test reset done");

      // Each mode in turn from normal, then back to normal.
      for (int m = 1; m < 4; m++) begin
         reg_write(ADDR_POWER_MODE_CONTROL, 8'(m));
         if (m != 2) read_check("mode field", ADDR_POWER_MODE_CONTROL, 8'(m));
         check8("energy enable", {7'h00, m == 1}, {7'h00, energy_det_en});
         if (m == 2) check_gate("soft gating", G_SOFT);
         reg_write(ADDR_POWER_MODE_CONTROL, 8'h00);
         check_gate("back to normal", G_ON);
      end
      $display("test mode loop done");

      // Registers survive soft power-down; a refused write leaves them alone.
      reg_write(ADDR_SLEEP_DELAY_TIME, 8'h33);
      reg_write(ADDR_POWER_MODE_CONTROL, 8'h02);
      reg_write(ADDR_SLEEP_DELAY_TIME, 8'h77);
      reg_write(ADDR_POWER_MODE_CONTROL, 8'h00);
      check_gate("soft wake", G_ON);
      read_check("kept sleep time", ADDR_SLEEP_DELAY_TIME, 8'h33);
      $display("test soft down done");

      // Saving mode gates receivers by line energy and wakes a port on activity.
      autoneg_en = 1'h1;
      reg_write(ADDR_POWER_MODE_CONTROL, 8'h03);
      repeat (6) @(negedge clk);
      check_gate("saving idle", {1'h1, 1'h1, 1'h1, 2'h3, 2'h0, 1'h0, 1'h0});
      cable_energy = 2'h1;
      repeat (8) @(negedge clk);
      check_gate("saving wake", {1'h1, 1'h1, 1'h1, 2'h3, 2'h1, 1'h0, 1'h0});
      reg_write(ADDR_POWER_MODE_CONTROL, 8'h00);
      check_gate("saving exit", G_ON);
      cable_energy = 2'h0;
      autoneg_en = 1'h0;
      $display("test saving done");

      // One go-sleep step: awake just past one step, asleep within the next; the
      // first link pulse leaves on entry and lasts two cycles.
      reg_write(ADDR_SLEEP_DELAY_TIME, 8'h01);
      reg_write(ADDR_POWER_MODE_CONTROL, 8'h01);
      check8("link pulse on", 8'h03, {6'h00, link_pulse});
      @(negedge clk);
      check8("link pulse held", 8'h03, {6'h00, link_pulse});
      @(negedge clk);
      check8("link pulse off", 8'h00, {6'h00, link_pulse});
      repeat (SLEEP_UNIT_CYC + 10) @(negedge clk);
      check8("early sleep", 8'h00, {7'h00, low_power});
      wait_low(1'h1, SLEEP_UNIT_CYC);
      // Gating follows the low power flag one cycle later.
      @(negedge clk);
      check8("sleep gates", 8'h01, {5'h00, pll_en, mac_en, host_en, 1'h0} | 8'h01);
      check8("sleep detector", 8'h01, {7'h00, energy_det_en});
      cable_energy = 2'h2;
      wait_low(1'h0, 10);
      reg_write(ADDR_POWER_MODE_CONTROL, 8'h05);
      check8("pll off bit", 8'h00, {7'h00, pll_en});
      reg_write(ADDR_POWER_MODE_CONTROL, 8'h00);
      cable_energy = 2'h0;
      check_gate("energy exit", G_ON);
      $display("test energy detect done");

      // Port 1 alone, then both, then port 2 alone.
      reg_write(ADDR_PORT1_PHY_CONTROL, 8'h08);
      check_gate("port1 down", {1'h1, 1'h1, 1'h1, 2'h2, 2'h2, 1'h0, 1'h0});
      read_check("port1 field", ADDR_PORT1_PHY_CONTROL, 8'h08);
      reg_write(ADDR_PORT2_PHY_CONTROL, 8'h08);
      check_gate("both down", {1'h1, 1'h1, 1'h1, 2'h0, 2'h0, 1'h0, 1'h0});
      reg_write(ADDR_PORT1_PHY_CONTROL, 8'h00);
      check_gate("port2 down", {1'h1, 1'h1, 1'h1, 2'h1, 2'h1, 1'h0, 1'h0});
      reg_write(ADDR_PORT2_PHY_CONTROL, 8'h00);
      $display("test port down done");

      // Pin low switches the chip off; release restores it with registers kept.
      chip_sleep_pin_n = 1'h0;
      repeat (8) @(negedge clk);
      check_gate("pin down", G_PIN);
      chip_sleep_pin_n = 1'h1;
      repeat (8) @(negedge clk);
      check_gate("pin up", G_ON);
      read_check("pin kept", ADDR_SLEEP_DELAY_TIME, 8'h01);
      $display("test pin done");
      end_sim();
   end
endmodule // switch_power_mode_control_bench
